// ### verilog/hsc_strap_cfg.sv
// Decided for this implementation: the placing of the registers and the address-and-strobe port.
module hsc_strap_cfg (
   input wire logic clk_i,
   input wire logic sys_rst_i,
   input wire logic active_low_reset_pin_n_i,
   input wire hsc_pkg::hsc_strap_t strap_i,
   input wire logic [4:0] mac_rx_i,
   input wire hsc_pkg::hsc_bus_req_t bus_i,
   output hsc_pkg::hsc_strap_t strap_o,
   output hsc_pkg::hsc_strap_t strap_oe_n_o,
   output logic [hsc_pkg::DATA_W-1:0] rdata_o,
   output logic [4:0] phy_addr_o,
   output logic managed_o,
   output logic cfg_valid_o,
   output hsc_pkg::hsc_cfg_t cfg_o
);
   import hsc_pkg::*;

   // ---------------------------------------------------------------
   // State
   // ---------------------------------------------------------------
   hsc_state_t state_q;
   hsc_state_t state_d;
   hsc_strap_t sample_q;
   hsc_strap_t sample_d;
   hsc_strap_t cap_q;
   hsc_strap_t cap_d;
   logic managed_q;
   logic managed_d;
   logic [4:0] addr_q;
   logic [4:0] addr_d;
   hsc_cfg_t cfg_q;
   hsc_cfg_t cfg_d;
   logic clk_en_q;
   logic clk_en_d;
   logic [1:0] freq_q;
   logic [1:0] freq_d;
   logic [DATA_W-1:0] rdata_q;
   logic [DATA_W-1:0] rdata_d;
   hsc_strap_t pin_q;
   hsc_strap_t pin_d;
   hsc_strap_t oe_n_q;
   hsc_strap_t oe_n_d;
   logic div_clk;
   logic release_ev;
   logic valid_q;
   logic valid_d;
   logic div_run;

   // Release is the first clock at which the strap reset reads high while still holding.
   assign release_ev = (state_q == ST_HOLD) && active_low_reset_pin_n_i;

   // ---------------------------------------------------------------
   // Strap sampling and capture
   // ---------------------------------------------------------------
   // The pins are sampled on every clock while the strap reset is low, so the capture on release
   // takes the level of the last low cycle, after the pins have settled to their resistors.
   always_comb begin
      state_d = state_q;
      sample_d = sample_q;
      cap_d = cap_q;
      case (state_q)
         ST_HOLD: begin
            if (!active_low_reset_pin_n_i) begin
               sample_d = strap_i;
            end else begin
               cap_d = sample_q;
               state_d = ST_RUN;
            end
         end
         ST_RUN: begin
            if (!active_low_reset_pin_n_i) begin
               // Sampling reopens, but the captured values stand until the next release.
               state_d = ST_HOLD;
               sample_d = strap_i;
            end
         end
         default: state_d = ST_HOLD;
      endcase
      valid_d = (state_d == ST_RUN);
   end

   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         state_q <= ST_HOLD;
         sample_q <= '0;
         cap_q <= '0;
         valid_q <= 1'b0;
      end else begin
         state_q <= state_d;
         sample_q <= sample_d;
         cap_q <= cap_d;
         valid_q <= valid_d;
      end
   end

   // ---------------------------------------------------------------
   // Configuration registers and their defaults from the straps
   // ---------------------------------------------------------------
   // Software reaches every field in both modes; only the address and the mode are fixed.
   always_comb begin
      managed_d = managed_q;
      addr_d = addr_q;
      cfg_d = cfg_q;
      clk_en_d = clk_en_q;
      freq_d = freq_q;
      if (release_ev) begin
         clk_en_d = sample_q.auxiliary_clock_output;
         managed_d = ~sample_q.rxclk;
         // Defaults that hold in managed mode, where only software configures.
         cfg_d.rx_delay = DLY_RST;
         cfg_d.tx_delay = DLY_RST;
         cfg_d.rmii = 1'b0;
         cfg_d.aneg_en = 1'b1;
         cfg_d.adv_1000 = 1'b1;
         cfg_d.adv_100 = 1'b1;
         cfg_d.adv_10 = 1'b1;
         cfg_d.full_duplex = 1'b1;
         cfg_d.force_100 = 1'b0;
         cfg_d.downshift_en = 1'b0;
         cfg_d.sleep_en = 1'b0;
         if (!sample_q.rxclk) begin
            addr_d = {sample_q.e, sample_q.d, sample_q.c, sample_q.b, sample_q.a};
         end else begin
            addr_d = ADDR_UNMANAGED;
            cfg_d.rx_delay = {sample_q.a, sample_q.b, 1'b0};
            cfg_d.tx_delay = {sample_q.a, sample_q.b, 1'b0};
            // Inconsistent choices such as RMII with gigabit advertised are applied as strapped.
            cfg_d.rmii = sample_q.e;
            cfg_d.aneg_en = ~sample_q.c;
            cfg_d.adv_1000 = ~sample_q.c & ~sample_q.d;
            cfg_d.adv_100 = ~(sample_q.c & sample_q.d);
            cfg_d.adv_10 = ~sample_q.c | sample_q.d;
            cfg_d.full_duplex = ~sample_q.c;
            cfg_d.force_100 = sample_q.c & ~sample_q.d;
            cfg_d.downshift_en = 1'b1;
            cfg_d.sleep_en = 1'b1;
         end
      end else if (bus_i.wr && state_q == ST_RUN) begin
         // Writes before capture or in the release cycle are dropped, so the strap defaults
         // never silently replace a value that software has just written.
         case (bus_i.addr)
            REG_CLKCTL: begin
               clk_en_d = bus_i.wdata[CLK_EN_BIT];
               freq_d = bus_i.wdata[CLK_FREQ_LSB +: 2];
            end
            REG_MACCFG: begin
               cfg_d.rx_delay = bus_i.wdata[RXDLY_LSB +: 3];
               cfg_d.tx_delay = bus_i.wdata[TXDLY_LSB +: 3];
               cfg_d.rmii = bus_i.wdata[RMII_BIT];
            end
            REG_LINKCFG: begin
               cfg_d.aneg_en = bus_i.wdata[ANEG_BIT];
               cfg_d.adv_1000 = bus_i.wdata[ADV1000_BIT];
               cfg_d.adv_100 = bus_i.wdata[ADV100_BIT];
               cfg_d.adv_10 = bus_i.wdata[ADV10_BIT];
               cfg_d.full_duplex = bus_i.wdata[FDX_BIT];
               cfg_d.force_100 = bus_i.wdata[FORCE100_BIT];
            end
            REG_POWER: begin
               cfg_d.downshift_en = bus_i.wdata[DSHIFT_BIT];
               cfg_d.sleep_en = bus_i.wdata[SLEEP_BIT];
            end
            default: begin
               cfg_d = cfg_q;
            end
         endcase
      end
   end

   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         managed_q <= 1'b0;
         addr_q <= ADDR_UNMANAGED;
         cfg_q <= '0;
         clk_en_q <= 1'b0;
         freq_q <= FREQ_RST;
      end else begin
         managed_q <= managed_d;
         addr_q <= addr_d;
         cfg_q <= cfg_d;
         clk_en_q <= clk_en_d;
         freq_q <= freq_d;
      end
   end

   // ---------------------------------------------------------------
   // Register read port
   // ---------------------------------------------------------------
   // Read data stand for one cycle after the read strobe and are zero otherwise.
   always_comb begin
      rdata_d = '0;
      if (bus_i.rd) begin
         case (bus_i.addr)
            REG_CLKCTL: begin
               rdata_d[CLK_EN_BIT] = clk_en_q;
               rdata_d[CLK_FREQ_LSB +: 2] = freq_q;
            end
            REG_MACCFG: begin
               rdata_d[RXDLY_LSB +: 3] = cfg_q.rx_delay;
               rdata_d[TXDLY_LSB +: 3] = cfg_q.tx_delay;
               rdata_d[RMII_BIT] = cfg_q.rmii;
            end
            REG_LINKCFG: begin
               rdata_d[ANEG_BIT] = cfg_q.aneg_en;
               rdata_d[ADV1000_BIT] = cfg_q.adv_1000;
               rdata_d[ADV100_BIT] = cfg_q.adv_100;
               rdata_d[ADV10_BIT] = cfg_q.adv_10;
               rdata_d[FDX_BIT] = cfg_q.full_duplex;
               rdata_d[FORCE100_BIT] = cfg_q.force_100;
            end
            REG_POWER: begin
               rdata_d[DSHIFT_BIT] = cfg_q.downshift_en;
               rdata_d[SLEEP_BIT] = cfg_q.sleep_en;
            end
            REG_STATUS: begin
               rdata_d[ST_ADDR_LSB +: 5] = addr_q;
               rdata_d[ST_MANAGED_BIT] = managed_q;
               rdata_d[ST_DONE_BIT] = (state_q == ST_RUN);
               rdata_d[ST_STRAP_LSB +: STRAP_W] = cap_q;
            end
            default: rdata_d = '0;
         endcase
      end
   end

   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         rdata_q <= '0;
      end else begin
         rdata_q <= rdata_d;
      end
   end

   // ---------------------------------------------------------------
   // Clock output
   // ---------------------------------------------------------------
   // The system clock is faster than the nominal output rates, so each frequency code maps to a
   // half period counted in system clocks, which keeps the output locked to the reference.
   assign div_run = clk_en_q && (state_q == ST_RUN);

   hsc_clk_div u_clk_div (
      .clk_i(clk_i),
      .sys_rst_i(sys_rst_i),
      .run_i(div_run),
      .freq_i(freq_q),
      .clk_o(div_clk)
   );

   // ---------------------------------------------------------------
   // Shared pins: released in reset, driven once running
   // ---------------------------------------------------------------
   // Each pin is released from the clock that sees the strap reset low and driven again from
   // the release edge on, so the pull resistors alone set the levels sampled after the first low clock.
   always_comb begin
      pin_d = '0;
      oe_n_d = '1;
      if (state_d == ST_RUN) begin
         oe_n_d = '0;
         // A disabled clock output drives a steady low instead of being released.
         pin_d.auxiliary_clock_output = clk_en_q ? div_clk : 1'b0;
         pin_d.rxclk = mac_rx_i[4];
         {pin_d.e, pin_d.d, pin_d.c, pin_d.b, pin_d.a} = {1'b0, mac_rx_i[3:0]};
      end
   end

   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         pin_q <= '0;
         oe_n_q <= '1;
      end else begin
         pin_q <= pin_d;
         oe_n_q <= oe_n_d;
      end
   end

   assign strap_o = pin_q;
   assign strap_oe_n_o = oe_n_q;
   assign rdata_o = rdata_q;
   assign phy_addr_o = addr_q;
   assign managed_o = managed_q;
   assign cfg_valid_o = valid_q;
   assign cfg_o = cfg_q;

endmodule : hsc_strap_cfg

// ### verilog/hsc_pkg.sv
package hsc_pkg;

   // ---------------------------------------------------------------
   // Register bus geometry
   // ---------------------------------------------------------------
   localparam int ADDR_W = 4;
   localparam int DATA_W = 16;

   localparam logic [3:0] REG_CLKCTL = 4'h0;
   localparam logic [3:0] REG_MACCFG = 4'h1;
   localparam logic [3:0] REG_LINKCFG = 4'h2;
   localparam logic [3:0] REG_POWER = 4'h3;
   localparam logic [3:0] REG_STATUS = 4'h4;

   // ---------------------------------------------------------------
   // Field positions
   // ---------------------------------------------------------------
   localparam int CLK_EN_BIT = 15;
   localparam int CLK_FREQ_LSB = 13;
   localparam int RXDLY_LSB = 0;
   localparam int TXDLY_LSB = 4;
   localparam int RMII_BIT = 8;
   localparam int ANEG_BIT = 0;
   localparam int ADV1000_BIT = 1;
   localparam int ADV100_BIT = 2;
   localparam int ADV10_BIT = 3;
   localparam int FDX_BIT = 4;
   localparam int FORCE100_BIT = 5;
   localparam int DSHIFT_BIT = 4;
   localparam int SLEEP_BIT = 6;
   localparam int ST_ADDR_LSB = 0;
   localparam int ST_MANAGED_BIT = 5;
   localparam int ST_DONE_BIT = 6;
   localparam int ST_STRAP_LSB = 7;

   // ---------------------------------------------------------------
   // Values after reset and codes
   // ---------------------------------------------------------------
   localparam logic [1:0] FREQ_25 = 2'h0;
   localparam logic [1:0] FREQ_50 = 2'h1;
   localparam logic [1:0] FREQ_125 = 2'h2;
   localparam logic [1:0] FREQ_RST = 2'h0;
   localparam logic [2:0] DLY_RST = 3'h2;
   localparam logic [4:0] ADDR_UNMANAGED = 5'h00;

   // Half periods of the clock output in system clock cycles.
   localparam logic [2:0] HALF_25 = 3'h4;
   localparam logic [2:0] HALF_50 = 3'h2;
   localparam logic [2:0] HALF_125 = 3'h1;

   // Strap field of the status register is 7 bits wide.
   localparam int STRAP_W = 7;

   typedef struct packed {
      logic auxiliary_clock_output;
      logic rxclk;
      logic e;
      logic d;
      logic c;
      logic b;
      logic a;
   } hsc_strap_t;

   typedef struct packed {
      logic [2:0] rx_delay;
      logic [2:0] tx_delay;
      logic rmii;
      logic aneg_en;
      logic adv_1000;
      logic adv_100;
      logic adv_10;
      logic full_duplex;
      logic force_100;
      logic downshift_en;
      logic sleep_en;
   } hsc_cfg_t;

   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
      logic wr;
      logic rd;
   } hsc_bus_req_t;

   typedef enum logic [0:0] {
      ST_HOLD = 1'b0,
      ST_RUN = 1'b1
   } hsc_state_t;

endpackage : hsc_pkg

// ### verilog/hsc_clk_div.sv
module hsc_clk_div (
   input wire logic clk_i,
   input wire logic sys_rst_i,
   input wire logic run_i,
   input wire logic [1:0] freq_i,
   output logic clk_o
);
   import hsc_pkg::*;

   logic [2:0] cnt_q;
   logic [2:0] cnt_d;
   logic clk_q;
   logic clk_d;
   logic [2:0] half;

   // ---------------------------------------------------------------
   // Divider locked to the system clock
   // ---------------------------------------------------------------
   always_comb begin
      case (freq_i)
         FREQ_50: half = HALF_50;
         FREQ_125: half = HALF_125;
         default: half = HALF_25;
      endcase
      cnt_d = cnt_q;
      clk_d = clk_q;
      if (!run_i) begin
         cnt_d = 3'h0;
         clk_d = 1'b0;
      end else if (cnt_q + 3'h1 >= half) begin
         cnt_d = 3'h0;
         clk_d = ~clk_q;
      end else begin
         cnt_d = cnt_q + 3'h1;
      end
   end

   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         cnt_q <= 3'h0;
         clk_q <= 1'b0;
      end else begin
         cnt_q <= cnt_d;
         clk_q <= clk_d;
      end
   end

   assign clk_o = clk_q;

endmodule : hsc_clk_div

// ### testbench/hsc_pull_model.sv
module hsc_pull_model (
   input wire hsc_pkg::hsc_strap_t pull_i,
   input wire hsc_pkg::hsc_strap_t drv_i,
   input wire hsc_pkg::hsc_strap_t drv_oe_n_i,
   output hsc_pkg::hsc_strap_t pin_o
);
   timeunit 1ns;
   timeprecision 1ns;
   import hsc_pkg::*;
   // ---------------------------------------------------------------
   // Pin levels
   // ---------------------------------------------------------------
   // A released pin settles to its resistor, nothing else drives it in reset.
   assign pin_o = (drv_oe_n_i & pull_i) | (~drv_oe_n_i & drv_i);
endmodule : hsc_pull_model

// ### testbench/hsc_strap_cfg_props.sv
module hsc_strap_cfg_props (
   input wire logic clk_i,
   input wire logic sys_rst_i,
   input wire logic active_low_reset_pin_n_i,
   input wire hsc_pkg::hsc_strap_t strap_i,
   input wire hsc_pkg::hsc_strap_t strap_o,
   input wire hsc_pkg::hsc_strap_t strap_oe_n_o,
   input wire logic [4:0] phy_addr_o,
   input wire logic managed_o,
   input wire logic cfg_valid_o,
   input wire hsc_pkg::hsc_cfg_t cfg_o
);
   timeunit 1ns;
   timeprecision 1ns;
   import hsc_pkg::*;
   hsc_strap_t s1_q;
   hsc_strap_t s2_q;
   wire logic pn = active_low_reset_pin_n_i;
   default clocking @(posedge clk_i); endclocking
   default disable iff (sys_rst_i);
   // ---------------------------------------------------------------
   // Helpers
   // ---------------------------------------------------------------
   // The second stage holds the last low sample one cycle after release.
   always_ff @(posedge clk_i) begin
      s1_q <= strap_i;
      s2_q <= s1_q;
   end
   sequence rel;
      !pn ##1 pn;
   endsequence
   property p_hold;
      !pn |=> strap_oe_n_o == 7'h7f && !cfg_valid_o;
   endproperty
   a_hold: assert property (p_hold) else $error("pins driven in reset");
   property p_start;
      rel |=> cfg_valid_o && strap_oe_n_o == 7'h00;
   endproperty
   a_start: assert property (p_start) else $error("no capture on release");
   property p_mode;
      rel |=> managed_o == !s2_q.rxclk;
   endproperty
   a_mode: assert property (p_mode) else $error("wrong mode");
   property p_addr;
      rel |=> phy_addr_o == (s2_q.rxclk ? 5'h00 : s2_q[4:0]);
   endproperty
   a_addr: assert property (p_addr) else $error("wrong address");
   property p_dly;
      rel ##1 s2_q.rxclk |-> cfg_o.rx_delay == {s2_q.a, s2_q.b, 1'b0}
         && cfg_o.tx_delay == cfg_o.rx_delay;
   endproperty
   a_dly: assert property (p_dly) else $error("wrong delay code");
   property p_link;
      rel ##1 s2_q.rxclk |-> cfg_o.aneg_en == !s2_q.c
         && cfg_o.force_100 == (s2_q.c && !s2_q.d);
   endproperty
   a_link: assert property (p_link) else $error("wrong link setup");
   property p_mac;
      rel |=> cfg_o.rmii == (s2_q.rxclk && s2_q.e);
   endproperty
   a_mac: assert property (p_mac) else $error("wrong mac mode");
   property p_pwr;
      rel |=> cfg_o.downshift_en == s2_q.rxclk && cfg_o.sleep_en == s2_q.rxclk;
   endproperty
   a_pwr: assert property (p_pwr) else $error("wrong power defaults");
   property p_keep;
      cfg_valid_o && pn |=> $stable(phy_addr_o) && $stable(managed_o);
   endproperty
   a_keep: assert property (p_keep) else $error("capture changed");
   property p_off;
      rel ##1 !s2_q.auxiliary_clock_output |-> !strap_o.auxiliary_clock_output [*4];
   endproperty
   a_off: assert property (p_off) else $error("clock pin not low");
   property p_on;
      rel ##1 s2_q.auxiliary_clock_output |-> ##[1:8] strap_o.auxiliary_clock_output;
   endproperty
   a_on: assert property (p_on) else $error("clock output idle");
   c_man: cover property (rel ##1 managed_o);
   c_rmii: cover property (rel ##1 cfg_o.rmii);
   c_clk: cover property ($rose(strap_o.auxiliary_clock_output));
endmodule : hsc_strap_cfg_props

bind hsc_strap_cfg hsc_strap_cfg_props i_props (.clk_i, .sys_rst_i,
   .active_low_reset_pin_n_i, .strap_i, .strap_o, .strap_oe_n_o, .phy_addr_o,
   .managed_o, .cfg_valid_o, .cfg_o);

// ### testbench/tb_top.sv
module tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   import hsc_pkg::*;
   logic clk_i = 1'b0;
   logic sys_rst_i = 1'b1;
   logic pin_n = 1'b0;
   logic [4:0] mac_rx = 5'h00;
   hsc_strap_t pull = '0;
   hsc_bus_req_t bus = '0;
   hsc_strap_t pins;
   hsc_strap_t drv;
   hsc_strap_t oe_n;
   logic [15:0] rdata;
   logic [4:0] addr;
   logic managed;
   logic valid;
   hsc_cfg_t cfg;
   int bad_count = 0;
   int num_checks = 0;
   int seed = 89;
   int n;
   logic [15:0] d;
   logic [15:0] w;
   logic [1:0] codes [4] = '{FREQ_25, FREQ_50, FREQ_125, 2'h3};
   logic [2:0] halves [4] = '{HALF_25, HALF_50, HALF_125, HALF_25};

   initial forever #25 clk_i = ~clk_i;

   hsc_strap_cfg i_dut (.clk_i, .sys_rst_i, .active_low_reset_pin_n_i(pin_n),
      .strap_i(pins), .mac_rx_i(mac_rx), .bus_i(bus), .strap_o(drv),
      .strap_oe_n_o(oe_n), .rdata_o(rdata), .phy_addr_o(addr), .managed_o(managed),
      .cfg_valid_o(valid), .cfg_o(cfg));
   hsc_pull_model i_pull (.pull_i(pull), .drv_i(drv), .drv_oe_n_i(oe_n), .pin_o(pins));

   // ---------------------------------------------------------------
   // Checking and bus tasks
   // ---------------------------------------------------------------
   task automatic end_sim();
      if (bad_count == 0 && num_checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : end_sim

   task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
      num_checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk

   task automatic wr(input logic [3:0] a, input logic [15:0] v);
      @(posedge clk_i);
      bus <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
      @(posedge clk_i);
      bus.wr <= 1'b0;
   endtask : wr

   task automatic rd(input logic [3:0] a, output logic [15:0] v);
      @(posedge clk_i);
      bus <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
      @(posedge clk_i);
      bus.rd <= 1'b0;
      #1 v = rdata;
   endtask : rd

   task automatic wait_lvl(input logic l);
      int k;
      k = 0;
      while (drv.auxiliary_clock_output !== l) begin
         @(posedge clk_i);
         #1 k++;
         if (k > 20) begin
            chk("clk_wait", 16'h0001, 16'h0000);
            end_sim();
         end
      end
   endtask : wait_lvl

   function automatic hsc_cfg_t exp_cfg(input hsc_strap_t v);
      logic u;
      logic [1:0] cd;
      logic [2:0] dl;
      u = v.rxclk;
      cd = u ? {v.c, v.d} : 2'b00;
      dl = u ? {v.a, v.b, 1'b0} : DLY_RST;
      return {dl, dl, u & v.e, !cd[1], cd == 2'b00, cd != 2'b11, cd != 2'b10,
         !cd[1], cd == 2'b10, u, u};
   endfunction : exp_cfg

   task automatic cap(input hsc_strap_t v);
      logic u;
      u = v.rxclk;
      @(posedge clk_i);
      pin_n <= 1'b0;
      pull <= v;
      mac_rx <= 5'($random(seed));
      repeat (3) @(posedge clk_i);
      #1 chk("oe_n", 16'(oe_n), 16'h007f);
      chk("valid", 16'(valid), 16'h0000);
      wr(REG_POWER, 16'h0050);
      @(posedge clk_i);
      pin_n <= 1'b1;
      @(posedge clk_i);
      #1 chk("addr", 16'(addr), 16'(u ? 5'h00 : v[4:0]));
      chk("managed", 16'(managed), 16'(!u));
      chk("cfg", 16'(cfg), 16'(exp_cfg(v)));
      chk("oe_n_run", 16'(oe_n), 16'h0000);
      chk("pins_run", 16'(drv[5:0]), 16'({mac_rx[4], 1'b0, mac_rx[3:0]}));
      rd(REG_STATUS, d);
      chk("status", d, {2'b00, v, 1'b1, !u, u ? 5'h00 : v[4:0]});
      @(posedge clk_i);
      mac_rx <= 5'($random(seed));
      repeat (3) @(posedge clk_i);
      #1 chk("addr_kept", 16'(addr), 16'(u ? 5'h00 : v[4:0]));
      chk("cfg_kept", 16'(cfg), 16'(exp_cfg(v)));
      if (!v.auxiliary_clock_output) begin
         chk("clk_low", 16'(drv.auxiliary_clock_output), 16'h0000);
      end
   endtask : cap

   // ---------------------------------------------------------------
   // Main sequence
   // ---------------------------------------------------------------
   initial begin
      repeat (12) @(posedge clk_i);
      sys_rst_i <= 1'b0;
      for (int i = 0; i < 128; i++) begin
         cap(7'(i));
      end
      w = 16'($random(seed));
      wr(REG_MACCFG, w);
      rd(REG_MACCFG, d);
      chk("maccfg", d, w & 16'h0177);
      chk("cfg_delay", 16'(cfg.rx_delay), 16'(w[2:0]));
      wr(4'hf, 16'hffff);
      rd(4'hf, d);
      chk("unmapped", d, 16'h0000);
      for (int k = 0; k < 4; k++) begin
         w = {1'b1, codes[k], 13'h0000};
         wr(REG_CLKCTL, w);
         rd(REG_CLKCTL, d);
         chk("clkctl", d, w);
         wait_lvl(1'b0);
         wait_lvl(1'b1);
         n = 0;
         while (drv.auxiliary_clock_output === 1'b1 && n < 20) begin
            @(posedge clk_i);
            #1 n++;
         end
         chk("half", 16'(n), 16'(halves[k]));
      end
      wr(REG_CLKCTL, 16'h0000);
      repeat (2) @(posedge clk_i);
      repeat (8) begin
         @(posedge clk_i);
         #1 chk("clk_off", 16'(drv.auxiliary_clock_output), 16'h0000);
      end
      end_sim();
   end
endmodule : tb_top
